// ### supervisor_pkg.sv
package supervisor_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned STRETCH_TIME_MS = 200;
   localparam int unsigned WDOG_TIME_MS = 1600;
   // cycles = ms * 1e6 / period_ns
   localparam longint unsigned STRETCH_CYCLES =
      (64'(STRETCH_TIME_MS) * 64'd1_000_000) / 64'(CLK_PERIOD_NS);
   localparam longint unsigned WDOG_CYCLES =
      (64'(WDOG_TIME_MS) * 64'd1_000_000) / 64'(CLK_PERIOD_NS);
   localparam int unsigned CNT_W = 32;
   // ****************************************
   // reset states
   // ****************************************
   typedef enum logic [1:0] {
      RST_HOLD = 2'b00,
      RST_STRETCH = 2'b01,
      RST_RUN = 2'b10
   } rst_state_type;
endpackage : supervisor_pkg

// ### pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser, change taken when stages 2 and 3 agree
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // pin and clean level
   input wire logic pinIn,
   output logic levelOut
);
   logic [2:0] stage_r;
   logic [2:0] stage_nxt;
   logic level_r;
   logic level_nxt;

   always_comb begin
      stage_nxt = {stage_r[1:0], pinIn};
      level_nxt = level_r;
      if (stage_r[1] == stage_r[2]) begin
         level_nxt = stage_r[2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stage_r <= {3{INIT}};
         level_r <= INIT;
      end else begin
         stage_r <= stage_nxt;
         level_r <= level_nxt;
      end
   end

   assign levelOut = level_r;
endmodule : pin_sync
`default_nettype wire

// ### supervisor_reset_watchdog.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - low supply drives active-high reset high and active-low reset low (low-only when watchdog variant).
// - after low supply clears, reset is held for a 200 ms stretch and then released.
// - an outside pull-down of the active-low reset pin is a manual reset held through the stretch.
// - each edge of the watchdog kick input restarts the watchdog count from zero.
// - with no kick edge for 1.6 s, reset is asserted and followed by the normal stretch.
// - memory write inhibit is asserted whenever the supply is below threshold, from power-up.
// - the auxiliary low output is driven low while the auxiliary sense is below reference.
module supervisor_reset_watchdog
   import supervisor_pkg::*;
#(
   parameter bit HAS_WATCHDOG = 1'b1,
   parameter longint unsigned STRETCH_COUNT = STRETCH_CYCLES,
   parameter longint unsigned WDOG_COUNT = WDOG_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // analog comparator results
   input wire logic supplyLow,
   input wire logic aux_sense_in,
   // watchdog kick pin
   input wire logic watchdog_kick_in,
   // active-low reset pin, open drain
   input wire logic resetNIn,
   output logic resetNOut,
   output logic resetNOe,
   // active-high reset, open drain (two-output variant)
   output logic resetHighOut,
   output logic resetHighOe,
   // auxiliary low, open drain
   output logic aux_low_out,
   output logic auxLowOe,
   // memory write inhibit
   output logic writeInhibit
);
   import supervisor_pkg::*;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic supplyLowSync;
   logic auxLowSync;
   logic kickSync;
   logic resetPinSync;

   // low supply assumed at power-up so writes stay blocked
   pin_sync #(.INIT(1'b1)) u_sync_supply (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pinIn(supplyLow),
      .levelOut(supplyLowSync)
   );
   pin_sync #(.INIT(1'b0)) u_sync_aux (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pinIn(aux_sense_in),
      .levelOut(auxLowSync)
   );
   pin_sync #(.INIT(1'b0)) u_sync_kick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pinIn(watchdog_kick_in),
      .levelOut(kickSync)
   );
   pin_sync #(.INIT(1'b0)) u_sync_pin (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pinIn(resetNIn),
      .levelOut(resetPinSync)
   );

   // ****************************************
   // reset sequencer and watchdog
   // ****************************************
   rst_state_type state_r;
   rst_state_type state_nxt;
   logic [CNT_W-1:0] stretchCnt_r;
   logic [CNT_W-1:0] stretchCnt_nxt;
   logic [CNT_W-1:0] wdogCnt_r;
   logic [CNT_W-1:0] wdogCnt_nxt;
   logic kickPrev_r;
   logic kickPrev_nxt;
   logic pinArmed_r;
   logic pinArmed_nxt;
   logic manualReset;
   logic kickEdge;
   logic wdogExpire;

   // our own pull-down lingers in the synchroniser after release, so the pin
   // must be seen high once in run before a low level counts as manual reset;
   // limitation: a button held past the stretch is not seen again until released
   assign manualReset = (state_r == RST_RUN) && pinArmed_r && !resetPinSync;
   assign kickEdge = kickSync ^ kickPrev_r;
   assign wdogExpire = HAS_WATCHDOG && (wdogCnt_r >= CNT_W'(WDOG_COUNT - 1));

   always_comb begin
      state_nxt = state_r;
      stretchCnt_nxt = stretchCnt_r;
      wdogCnt_nxt = wdogCnt_r;
      kickPrev_nxt = kickSync;
      pinArmed_nxt = 1'b0;
      unique case (state_r)
         RST_HOLD: begin
            stretchCnt_nxt = '0;
            wdogCnt_nxt = '0;
            if (!supplyLowSync) begin
               state_nxt = RST_STRETCH;
            end
         end
         RST_STRETCH: begin
            wdogCnt_nxt = '0;
            stretchCnt_nxt = stretchCnt_r + CNT_W'(1);
            if (supplyLowSync) begin
               state_nxt = RST_HOLD;
            end else if (stretchCnt_r >= CNT_W'(STRETCH_COUNT - 1)) begin
               state_nxt = RST_RUN;
            end
         end
         RST_RUN: begin
            pinArmed_nxt = pinArmed_r || resetPinSync;
            if (kickEdge) begin
               wdogCnt_nxt = '0;
            end else begin
               wdogCnt_nxt = wdogCnt_r + CNT_W'(1);
            end
            if (supplyLowSync || manualReset) begin
               state_nxt = RST_HOLD;
            end else if (wdogExpire) begin
               state_nxt = RST_STRETCH;
               stretchCnt_nxt = '0;
               wdogCnt_nxt = '0;
            end
         end
         default: begin
            state_nxt = RST_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= RST_HOLD;
         stretchCnt_r <= '0;
         wdogCnt_r <= '0;
         kickPrev_r <= 1'b0;
         pinArmed_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         stretchCnt_r <= stretchCnt_nxt;
         wdogCnt_r <= wdogCnt_nxt;
         kickPrev_r <= kickPrev_nxt;
         pinArmed_r <= pinArmed_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic resetActive_r;
   logic resetActive_nxt;
   logic auxLow_r;
   logic auxLow_nxt;
   logic inhibit_r;
   logic inhibit_nxt;

   always_comb begin
      // hold through stretch, which starts once a manual reset is detected, not on pin release
      resetActive_nxt = (state_nxt != RST_RUN);
      auxLow_nxt = auxLowSync;
      inhibit_nxt = supplyLowSync;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         resetActive_r <= 1'b1;
         auxLow_r <= 1'b0;
         inhibit_r <= 1'b1;
      end else begin
         resetActive_r <= resetActive_nxt;
         auxLow_r <= auxLow_nxt;
         inhibit_r <= inhibit_nxt;
      end
   end

   assign resetNOut = 1'b0;
   assign resetNOe = resetActive_r;
   // only the two-output variant has the active-high pin
   assign resetHighOut = 1'b1;
   assign resetHighOe = resetActive_r && !HAS_WATCHDOG;
   assign aux_low_out = 1'b0;
   assign auxLowOe = auxLow_r;
   assign writeInhibit = inhibit_r;
endmodule : supervisor_reset_watchdog
`default_nettype wire

// ### supervisor_checker.sv
`timescale 1ns/1ns
`default_nettype none
module supervisor_checker #(
   parameter int STRETCH_COUNT = 50,
   parameter int WDOG_COUNT = 200
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // watched pins
   input wire logic supplyLow,
   input wire logic aux_sense_in,
   input wire logic watchdog_kick_in,
   input wire logic resetNIn,
   input wire logic resetNOe,
   input wire logic resetHighOe,
   input wire logic auxLowOe,
   input wire logic writeInhibit
);
   localparam int SM = STRETCH_COUNT - 1;
   logic [31:0] idle_r;
   logic [31:0] idle_nxt;
   logic kick_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // cycles since last kick edge, held at zero during reset
   always_comb begin
      idle_nxt = (resetNOe || kick_r != watchdog_kick_in) ? 32'h0000_0000 : idle_r + 1;
   end
   always_ff @(posedge core_clk) begin
      idle_r <= sys_rst ? 32'h0000_0000 : idle_nxt;
      kick_r <= watchdog_kick_in;
   end
   sequence held_s;
      resetNOe throughout ##SM 1;
   endsequence
   // ********
   // rules
   // ********
   supply_rst_a: assert property (supplyLow |-> ##[2:6] resetNOe)
      else $error("reset not driven on low supply");
   high_idle_a: assert property (!resetHighOe)
      else $error("active-high pin driven");
   supply_stretch_a: assert property ($fell(supplyLow) |-> held_s ##[1:12] !resetNOe)
      else $error("bad stretch after supply");
   manual_det_a: assert property (!resetNIn && !resetNOe |-> ##[2:6] resetNOe)
      else $error("manual reset missed");
   stretch_len_a: assert property ($rose(resetNOe) && !supplyLow |-> held_s ##[1:12] !resetNOe)
      else $error("bad stretch length");
   wdog_early_a: assert property ($rose(resetNOe) |->
      supplyLow || !$past(resetNIn, 2) || idle_r >= 32'(WDOG_COUNT))
      else $error("watchdog fired early");
   wdog_late_a: assert property (idle_r < 32'(WDOG_COUNT + 12))
      else $error("watchdog never fired");
   inhibit_a: assert property (supplyLow |-> ##[2:6] writeInhibit)
      else $error("write not inhibited");
   aux_low_a: assert property (aux_sense_in |-> ##[2:6] auxLowOe)
      else $error("aux low not driven");
   aux_rel_a: assert property (!aux_sense_in |-> ##[2:6] !auxLowOe)
      else $error("aux low not released");
endmodule : supervisor_checker
bind supervisor_reset_watchdog supervisor_checker #(
   .STRETCH_COUNT(int'(STRETCH_COUNT)), .WDOG_COUNT(int'(WDOG_COUNT))
) i_chk (.core_clk, .sys_rst, .supplyLow, .aux_sense_in, .watchdog_kick_in, .resetNIn,
   .resetNOe, .resetHighOe, .auxLowOe, .writeInhibit);
`default_nettype wire

// ### kick_mcu.sv
`timescale 1ns/1ns
`default_nettype none
module kick_mcu #(
   parameter int PERIOD = 180
) (
   // clock, hang control and reset wire
   input wire logic core_clk,
   input wire logic kickOn,
   input wire logic resetNIn,
   // kick pin
   output logic watchdog_kick_in
);
   int cnt = 0;
   logic kick_r = 1'b0;
   assign watchdog_kick_in = kick_r;
   always @(negedge core_clk) begin
      cnt = (kickOn && resetNIn && cnt < PERIOD) ? cnt + 1 : 0;
      if (cnt == PERIOD) kick_r <= !kick_r;
   end
endmodule : kick_mcu
`default_nettype wire

// ### supervisor_reset_watchdog_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module supervisor_reset_watchdog_tb_top;
   localparam int SC = 50;
   localparam int WC = 200;
   logic core_clk, sys_rst, supplyLow, aux_sense_in, manPull, kickOn, resetNIn;
   logic resetNOut, resetNOe, resetHighOut, resetHighOe;
   logic aux_low_out, auxLowOe, writeInhibit, watchdog_kick_in;
   int num_errors = 0;
   int total_checks = 0;
   int n;
   // {supply, aux} then {reset, auxlow, inhibit}
   logic [4:0] rows [5] = '{5'h1F, 5'h00, 5'h0A, 5'h15, 5'h00};
   // wire level: pulled low by either party
   assign resetNIn = !(resetNOe || manPull);
   supervisor_reset_watchdog #(.STRETCH_COUNT(SC), .WDOG_COUNT(WC)) i_dut (.core_clk, .sys_rst,
      .supplyLow, .aux_sense_in, .watchdog_kick_in, .resetNIn, .resetNOut, .resetNOe,
      .resetHighOut, .resetHighOe, .aux_low_out, .auxLowOe, .writeInhibit);
   kick_mcu #(.PERIOD(180)) i_mcu (.core_clk, .kickOn, .resetNIn, .watchdog_kick_in);
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_rst(input logic v, output int c);
      c = 0;
      while (resetNOe !== v && c < 400) begin
         @(negedge core_clk);
         c++;
      end
   endtask : wait_rst
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = !core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      final_report();
   end
   initial begin
      {sys_rst, supplyLow, aux_sense_in, manPull, kickOn} = 5'h19;
      repeat (6) @(negedge core_clk);
      check({resetNOe, auxLowOe, writeInhibit}, 3'h5);
      check({resetNOut, aux_low_out, resetHighOe}, 3'h0);
      check({2'h0, resetHighOut}, 3'h1);
      sys_rst = 1'b0;
      for (int i = 0; i < 5; i++) begin
         {supplyLow, aux_sense_in} = rows[i][4:3];
         repeat (80) @(negedge core_clk);
         check({resetNOe, auxLowOe, writeInhibit}, rows[i][2:0]);
      end
      // ********
      // short brown-out, manual reset, watchdog
      // ********
      supplyLow = 1'b1;
      repeat (8) @(negedge core_clk);
      supplyLow = 1'b0;
      wait_rst(1'b0, n);
      check(3'(n >= SC && n <= SC + 8), 3'h1);
      // own pull-down must not read back as a manual reset
      repeat (10) @(negedge core_clk);
      check(3'(resetNOe), 3'h0);
      manPull = 1'b1;
      repeat (10) @(negedge core_clk);
      manPull = 1'b0;
      check(3'(resetNOe), 3'h1);
      wait_rst(1'b0, n);
      check(3'(n >= SC - 14 && n <= SC + 8), 3'h1);
      kickOn = 1'b0;
      wait_rst(1'b1, n);
      check(3'(n >= WC && n <= WC + 12), 3'h1);
      wait_rst(1'b0, n);
      check(3'(n >= SC && n <= SC + 8), 3'h1);
      kickOn = 1'b1;
      wait_rst(1'b1, n);
      check(3'(n == 400), 3'h1);
      // mid-run reset: power-up values, then a full stretch
      sys_rst = 1'b1;
      repeat (2) @(negedge core_clk);
      check({resetNOe, auxLowOe, writeInhibit}, 3'h5);
      sys_rst = 1'b0;
      wait_rst(1'b0, n);
      check(3'(n >= SC && n <= SC + 8), 3'h1);
      final_report();
   end
endmodule : supervisor_reset_watchdog_tb_top
`default_nettype wire
